// [tmr_params.svh]
// Register offsets, field positions and reset values of the 16-bit timer
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH
`define TMR_ADDR_FLAGS     3'h0
`define TMR_ADDR_ENABLES   3'h1
`define TMR_ADDR_PRIO      3'h2
`define TMR_ADDR_CNT_LOW   3'h3
`define TMR_ADDR_CNT_HIGH  3'h4
`define TMR_ADDR_CTRL      3'h5
`define TMR_ADDR_OSC_CTRL  3'h6
`define TMR_BIT_OVF        0
`define TMR_BIT_IDLE       7
`define TMR_SCS_OSC        2'h1
`define TMR_CMP_SPECIAL    4'hB
`define TMR_CNT_MAX        16'hFFFF
`define TMR_CNT_ZERO       16'h0000
`define TMR_RST_BYTE       8'h00
`endif

// [tmr_pkg.sv]
// Types shared by the 16-bit timer
package tmr_pkg;
    typedef struct packed {
        logic       wide_access_enable;
        logic       osc_clock_status;
        logic [1:0] input_prescale_select;
        logic       osc_enable;
        logic       skip_input_sync;
        logic       external_clock_select;
        logic       counter_on;
    } tmr_ctrl_s;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tmr_bus_s;

    typedef enum logic [2:0] {
        TMR_MODE_PRIMARY  = 3'b001,
        TMR_MODE_SEC_RUN  = 3'b010,
        TMR_MODE_SEC_IDLE = 3'b100
    } tmr_mode_e;
endpackage

// [tmr_top.sv]
// 16-bit timer/counter with oscillator clock source and register port
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_params.svh"

// Overview of operation
// - Status bit set while the timer oscillator clocks the device.
// - Clock select written 01 enters secondary run on the timer oscillator.
// - Sleep with idle bit clear under timer oscillator enters secondary idle.
// - Count bytes form one 16-bit up counter wrapping FFFF to 0000.
// - Each wrap latches the overflow flag until software clears it.
// - Overflow flag raises an interrupt only while its enable bit is set.
// - Compare mode 1011 trigger from an owning compare unit resets counter.
// - Trigger reset honoured in timer or synchronous counter mode only.
// - Compare value pair thus acts as the counting period.
// - Counter write in the trigger cycle wins over the reset.
// - Trigger reset never sets the overflow flag.
// - Prescale field divides count clock by 1, 2, 4 or 8.
// - Clear select counts instruction cycles; set counts input rising edges.
// - Wide mode buffers high byte on low read and loads it on low write.
// - Low byte write clears the prescaler; high byte write leaves it.
module tmr_top (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       ext_clk_i,
    input  wire logic       osc_clk_i,
    input  wire logic       cmp_trig_i,
    input  wire logic [3:0] cmp_mode_i,
    input  wire logic       cmp_uses_timer_i,
    input  wire logic       sleep_i,
    input  wire logic       wake_i,
    output logic            irq_o,
    output logic            irq_prio_o,
    output logic            osc_clock_status_o,
    output logic            sec_run_o,
    output logic            sec_idle_o
);
    tmr_pkg::tmr_bus_s  bus;
    tmr_pkg::tmr_ctrl_s ctrl_r;
    tmr_pkg::tmr_mode_e mode_r;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [7:0]  hbuf_r;
    logic [2:0]  pre_r;
    logic [2:0]  pre_mask;
    logic        flag_r;
    logic        en_r;
    logic        prio_r;
    logic        idle_r;
    logic [1:0]  scs_r;
    logic [1:0]  pin_s1_r;
    logic [1:0]  pin_s2_r;
    logic        src_d_r;
    logic        src_lvl;
    logic        src_rise;
    logic        cnt_event;
    logic        pre_tick;
    logic        inc;
    logic        wr_low;
    logic        wr_high;
    logic        wr_cnt;
    logic        async_mode;
    logic        trig_eff;
    logic        wrap;

    assign bus.addr  = addr_i;
    assign bus.wdata = wdata_i;
    assign bus.wr    = wr_i;
    assign bus.rd    = rd_i;

    assign wr_low  = bus.wr && (bus.addr == `TMR_ADDR_CNT_LOW);
    assign wr_high = bus.wr && (bus.addr == `TMR_ADDR_CNT_HIGH);
    assign wr_cnt  = wr_low || (wr_high && !ctrl_r.wide_access_enable);

    // Two-stage synchronisers for external pin and oscillator
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pin_s1_r <= 2'h0;
            pin_s2_r <= 2'h0;
        end else begin
            pin_s1_r <= {osc_clk_i, ext_clk_i};
            pin_s2_r <= pin_s1_r;
        end
    end

    // Oscillator replaces the pin when enabled
    assign src_lvl = ctrl_r.osc_enable ? pin_s2_r[1] : pin_s2_r[0];

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            src_d_r <= 1'b0;
        end else begin
            src_d_r <= src_lvl;
        end
    end

    assign src_rise  = src_lvl && !src_d_r;
    assign cnt_event = ctrl_r.external_clock_select ? src_rise : 1'b1;
    assign pre_mask  = 3'((4'h1 << ctrl_r.input_prescale_select) - 4'h1);
    assign pre_tick  = cnt_event && (pre_r == pre_mask);
    assign inc       = ctrl_r.counter_on && pre_tick;

    // Prescaler counts qualified count events
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pre_r <= 3'h0;
        end else if (wr_low) begin
            pre_r <= 3'h0;
        end else if (ctrl_r.counter_on && cnt_event) begin
            pre_r <= pre_tick ? 3'h0 : pre_r + 3'h1;
        end
    end

    assign async_mode = ctrl_r.external_clock_select && ctrl_r.skip_input_sync;
    assign trig_eff   = cmp_trig_i && cmp_uses_timer_i
                        && (cmp_mode_i == `TMR_CMP_SPECIAL)
                        && !async_mode;
    assign wrap = inc && (cnt_r == `TMR_CNT_MAX) && !wr_cnt && !trig_eff;

    always_comb begin
        cnt_nxt = cnt_r;
        if (wr_low && ctrl_r.wide_access_enable) begin
            cnt_nxt = {hbuf_r, bus.wdata};
        end else if (wr_low) begin
            cnt_nxt = {cnt_r[15:8], bus.wdata};
        end else if (wr_cnt) begin
            cnt_nxt = {bus.wdata, cnt_r[7:0]};
        end else if (trig_eff) begin
            cnt_nxt = `TMR_CNT_ZERO;
        end else if (inc) begin
            cnt_nxt = cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cnt_r <= `TMR_CNT_ZERO;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // High byte buffer for wide access
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            hbuf_r <= `TMR_RST_BYTE;
        end else if (bus.rd && bus.addr == `TMR_ADDR_CNT_LOW
                     && ctrl_r.wide_access_enable) begin
            hbuf_r <= cnt_r[15:8];
        end else if (wr_high && ctrl_r.wide_access_enable) begin
            hbuf_r <= bus.wdata;
        end
    end

    // Overflow flag; a wrap beats a clear in the same cycle
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            flag_r <= 1'b0;
        end else if (wrap) begin
            flag_r <= 1'b1;
        end else if (bus.wr && bus.addr == `TMR_ADDR_FLAGS) begin
            flag_r <= bus.wdata[`TMR_BIT_OVF];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            en_r   <= 1'b0;
            prio_r <= 1'b0;
        end else if (bus.wr && bus.addr == `TMR_ADDR_ENABLES) begin
            en_r <= bus.wdata[`TMR_BIT_OVF];
        end else if (bus.wr && bus.addr == `TMR_ADDR_PRIO) begin
            prio_r <= bus.wdata[`TMR_BIT_OVF];
        end
    end

    // Control register; status bit follows the clock mode
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ctrl_r <= '0;
        end else begin
            if (bus.wr && bus.addr == `TMR_ADDR_CTRL) begin
                ctrl_r <= bus.wdata;
            end
            ctrl_r.osc_clock_status <= (mode_r != tmr_pkg::TMR_MODE_PRIMARY);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            idle_r <= 1'b0;
            scs_r  <= 2'h0;
        end else if (bus.wr && bus.addr == `TMR_ADDR_OSC_CTRL) begin
            idle_r <= bus.wdata[`TMR_BIT_IDLE];
            scs_r  <= bus.wdata[1:0];
        end
    end

    // Power mode sequencing on the timer oscillator
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            mode_r <= tmr_pkg::TMR_MODE_PRIMARY;
        end else begin
            unique case (mode_r)
                tmr_pkg::TMR_MODE_PRIMARY: begin
                    if (scs_r == `TMR_SCS_OSC) begin
                        mode_r <= tmr_pkg::TMR_MODE_SEC_RUN;
                    end
                end
                tmr_pkg::TMR_MODE_SEC_RUN: begin
                    if (scs_r != `TMR_SCS_OSC) begin
                        mode_r <= tmr_pkg::TMR_MODE_PRIMARY;
                    end else if (sleep_i && !idle_r) begin
                        mode_r <= tmr_pkg::TMR_MODE_SEC_IDLE;
                    end
                end
                tmr_pkg::TMR_MODE_SEC_IDLE: begin
                    if (wake_i) begin
                        mode_r <= tmr_pkg::TMR_MODE_SEC_RUN;
                    end
                end
                default: begin
                    mode_r <= tmr_pkg::TMR_MODE_PRIMARY;
                end
            endcase
        end
    end

    // Registered outputs
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            irq_o              <= 1'b0;
            irq_prio_o         <= 1'b0;
            osc_clock_status_o <= 1'b0;
            sec_run_o          <= 1'b0;
            sec_idle_o         <= 1'b0;
        end else begin
            irq_o              <= flag_r && en_r;
            irq_prio_o         <= prio_r;
            osc_clock_status_o <= ctrl_r.osc_clock_status;
            sec_run_o          <= (mode_r == tmr_pkg::TMR_MODE_SEC_RUN);
            sec_idle_o         <= (mode_r == tmr_pkg::TMR_MODE_SEC_IDLE);
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_o <= `TMR_RST_BYTE;
        end else if (bus.rd) begin
            unique case (bus.addr)
                `TMR_ADDR_FLAGS:    rdata_o <= {7'h00, flag_r};
                `TMR_ADDR_ENABLES:  rdata_o <= {7'h00, en_r};
                `TMR_ADDR_PRIO:     rdata_o <= {7'h00, prio_r};
                `TMR_ADDR_CNT_LOW:  rdata_o <= cnt_r[7:0];
                `TMR_ADDR_CNT_HIGH: rdata_o <= ctrl_r.wide_access_enable
                                               ? hbuf_r : cnt_r[15:8];
                `TMR_ADDR_CTRL:     rdata_o <= ctrl_r;
                `TMR_ADDR_OSC_CTRL: rdata_o <= {idle_r, 5'h00, scs_r};
                default:            rdata_o <= `TMR_RST_BYTE;
            endcase
        end else begin
            rdata_o <= `TMR_RST_BYTE;
        end
    end

    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    AST_WRAP: assert property (wrap |=> cnt_r == `TMR_CNT_ZERO && flag_r)
        else $error("Counter did not wrap to zero with flag");
    AST_STICKY: assert property (flag_r && !(bus.wr && bus.addr == `TMR_ADDR_FLAGS)
                                 |=> flag_r)
        else $error("Overflow flag lost without software clear");
    AST_IRQ: assert property (flag_r && en_r |=> irq_o ##1
                              (irq_o == $past(flag_r && en_r)))
        else $error("Interrupt not raised for enabled flag");
    AST_NOIRQ: assert property (!en_r |=> !irq_o)
        else $error("Interrupt raised while disabled");
    AST_TRIG: assert property (trig_eff && !wr_cnt |=> cnt_r == `TMR_CNT_ZERO)
        else $error("Compare trigger did not reset counter");
    AST_ASYNC: assert property (async_mode && !wr_cnt && !inc |=> cnt_r == $past(cnt_r))
        else $error("Trigger acted in asynchronous mode");
    AST_WRWIN: assert property (wr_low && !ctrl_r.wide_access_enable
                                |=> cnt_r[7:0] == $past(bus.wdata))
        else $error("Counter write lost to trigger");
    AST_NOFLAG: assert property (trig_eff && !flag_r && !bus.wr |=> !flag_r)
        else $error("Trigger reset set overflow flag");
    AST_PRECLR: assert property (wr_low |=> pre_r == 3'h0)
        else $error("Prescaler not cleared by low write");
    AST_WIDE: assert property (bus.rd && bus.addr == `TMR_ADDR_CNT_LOW
                               && ctrl_r.wide_access_enable
                               |=> hbuf_r == $past(cnt_r[15:8]))
        else $error("High byte buffer not loaded");
    AST_SECRUN: assert property (mode_r == tmr_pkg::TMR_MODE_SEC_RUN
                                 |=> ##1 osc_clock_status_o)
        else $error("Status bit not set in secondary run");
    AST_IDLE: assert property (mode_r == tmr_pkg::TMR_MODE_SEC_RUN && sleep_i && !idle_r
                               && scs_r == `TMR_SCS_OSC |=> ##1 sec_idle_o)
        else $error("Secondary idle not entered");

    COV_WRAP:  cover property (wrap ##[1:20] irq_o);
    COV_TRIG:  cover property (trig_eff ##1 cnt_r == `TMR_CNT_ZERO);
    COV_IDLE:  cover property (sec_run_o ##[1:10] sec_idle_o);
endmodule // tmr_top
`default_nettype wire

// [tmr_osc_model.sv]
// Behavioural timer oscillator and external count pin
`timescale 1ns/1ps
`default_nettype none
module tmr_osc_model (
    output logic ext_clk_o,
    output logic osc_clk_o
);
    initial begin
        ext_clk_o = 1'b0;
        osc_clk_o = 1'b0;
    end

    // Burst of rising edges every nine system clock periods, phase fixed by the call time; rests low between bursts
    task automatic burst(input int n, input bit use_osc);
        repeat (n) begin
            #170;
            if (use_osc) osc_clk_o = 1'b1;
            else ext_clk_o = 1'b1;
            #180;
            osc_clk_o = 1'b0;
            ext_clk_o = 1'b0;
            #10;
        end
    endtask
endmodule // tmr_osc_model
`default_nettype wire

// [test_tmr_top.sv]
// Self-checking testbench of the 16-bit timer
`timescale 1ns/1ps
`default_nettype none
`include "tmr_params.svh"
module test_tmr_top;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [2:0]  addr    = 3'h0;
    logic [7:0]  wdata   = 8'h00;
    logic        wr = 1'b0, rd = 1'b0, trig = 1'b0, uses = 1'b0, slp = 1'b0, wake = 1'b0;
    logic [3:0]  mode    = 4'h0;
    logic [7:0]  rdata, lo, hi;
    logic        ext_clk, osc_clk, irq, prio, stat, srun, sidle;
    logic [15:0] cnt;
    logic [3:0]  tmode [5] = '{4'hB, 4'hA, 4'hB, 4'hB, 4'hB};
    logic        tuse  [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    logic [7:0]  tctl  [5] = '{8'h00, 8'h00, 8'h00, 8'h06, 8'h02};
    int          n_mismatch = 0;
    int          comparisons = 0;

    always #20 clock_i = ~clock_i;

    tmr_osc_model partner (.ext_clk_o(ext_clk), .osc_clk_o(osc_clk));

    tmr_top uut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .ext_clk_i(ext_clk), .osc_clk_i(osc_clk),
        .cmp_trig_i(trig), .cmp_mode_i(mode), .cmp_uses_timer_i(uses), .sleep_i(slp),
        .wake_i(wake), .irq_o(irq), .irq_prio_o(prio), .osc_clock_status_o(stat),
        .sec_run_o(srun), .sec_idle_o(sidle)
    );

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_i);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clock_i);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock_i);
        {addr, rd} <= {a, 1'b1};
        @(posedge clock_i);
        rd <= 1'b0;
        @(negedge clock_i);
        d = rdata;
    endtask

    task automatic rcnt(output logic [15:0] v);
        rreg(`TMR_ADDR_CNT_LOW, lo);
        rreg(`TMR_ADDR_CNT_HIGH, hi);
        v = {hi, lo};
    endtask

    // High byte first so the low write completes the load
    task automatic ld(input logic [15:0] v);
        wreg(`TMR_ADDR_CNT_HIGH, v[15:8]);
        wreg(`TMR_ADDR_CNT_LOW, v[7:0]);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    task automatic strobe(input bit w);
        @(posedge clock_i);
        if (w) wake <= 1'b1;
        else slp <= 1'b1;
        @(posedge clock_i);
        {wake, slp} <= 2'b00;
        cyc(2);
    endtask

    task automatic endt(input string name);
        $display("test %s done", name);
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clock_i);
        n_mismatch++;
        conclude();
    end

    initial begin
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rreg(a[2:0], lo);
            chk("reset value", lo, 16'h0000);
        end
        wreg(3'h7, 8'hFF);
        rreg(3'h7, lo);
        chk("unmapped", lo, 16'h0000);
        wreg(`TMR_ADDR_PRIO, 8'h01);
        cyc(2);
        chk("priority", prio, 16'h0001);
        endt("reset");

        wreg(`TMR_ADDR_ENABLES, 8'h01);
        for (int ps = 3; ps >= 0; ps--) begin
            wreg(`TMR_ADDR_FLAGS, 8'h00);
            ld(16'hFFF8);
            wreg(`TMR_ADDR_CTRL, {2'b00, ps[1:0], 4'h1});
            cyc(14);
            wreg(`TMR_ADDR_CTRL, 8'h00);
            rcnt(cnt);
            chk("count", cnt, 16'hFFF8 + (16'h0010 >> ps));
            rreg(`TMR_ADDR_FLAGS, lo);
            chk("flag", lo, {7'h00, ps < 2});
            chk("irq", irq, ps < 2);
        end
        wreg(`TMR_ADDR_ENABLES, 8'h00);
        cyc(3);
        chk("irq masked", irq, 16'h0000);
        rreg(`TMR_ADDR_FLAGS, lo);
        chk("flag held", lo, 16'h0001);
        wreg(`TMR_ADDR_FLAGS, 8'h00);
        rreg(`TMR_ADDR_FLAGS, lo);
        chk("flag cleared", lo, 16'h0000);
        endt("wrap");

        // Byte write in mid-period, divide by 8
        for (int i = 0; i < 2; i++) begin
            ld(16'h0000);
            wreg(`TMR_ADDR_CTRL, 8'h31);
            cyc(5);
            wreg(i ? `TMR_ADDR_CNT_LOW : `TMR_ADDR_CNT_HIGH, 8'h00);
            cyc(7);
            wreg(`TMR_ADDR_CTRL, 8'h00);
            rcnt(cnt);
            chk("prescale clear", cnt, i ? 16'h0001 : 16'h0002);
        end
        endt("prescaler");

        wreg(`TMR_ADDR_CTRL, 8'h80);
        ld(16'h1234);
        wreg(`TMR_ADDR_CNT_HIGH, 8'h55);
        rcnt(cnt);
        chk("wide read", cnt, 16'h1234);
        endt("wide");

        for (int i = 0; i < 5; i++) begin
            wreg(`TMR_ADDR_CTRL, tctl[i]);
            ld(16'h1234);
            @(posedge clock_i);
            {mode, uses, trig} <= {tmode[i], tuse[i], 1'b1};
            @(posedge clock_i);
            trig <= 1'b0;
            rcnt(cnt);
            chk("trigger", cnt, (i == 0 || i == 4) ? 16'h0000 : 16'h1234);
        end
        rreg(`TMR_ADDR_FLAGS, lo);
        chk("trigger flag", lo, 16'h0000);
        ld(16'h1234);
        @(posedge clock_i);
        {addr, wdata, wr, trig} <= {`TMR_ADDR_CNT_LOW, 8'h77, 2'b11};
        @(posedge clock_i);
        {wr, trig} <= 2'b00;
        rcnt(cnt);
        chk("write wins", cnt, 16'h1277);
        endt("trigger");

        ld(16'h0000);
        wreg(`TMR_ADDR_CTRL, 8'h03);
        partner.burst(5, 1'b0);
        cyc(4);
        wreg(`TMR_ADDR_CTRL, 8'h0B);
        partner.burst(3, 1'b0);
        partner.burst(4, 1'b1);
        cyc(4);
        wreg(`TMR_ADDR_CTRL, 8'h00);
        rcnt(cnt);
        chk("edge count", cnt, 16'h0009);
        endt("external");

        // Clock-style use: async oscillator count, only the high byte MSb reloaded
        ld(16'hFFFE);
        wreg(`TMR_ADDR_ENABLES, 8'h01);
        wreg(`TMR_ADDR_CTRL, 8'h0F);
        partner.burst(2, 1'b1);
        cyc(4);
        chk("async irq", irq, 16'h0001);
        wreg(`TMR_ADDR_CNT_HIGH, 8'h80);
        wreg(`TMR_ADDR_FLAGS, 8'h00);
        partner.burst(3, 1'b1);
        cyc(4);
        wreg(`TMR_ADDR_CTRL, 8'h00);
        rcnt(cnt);
        chk("second tick", cnt, 16'h8003);
        rreg(`TMR_ADDR_FLAGS, lo);
        chk("async flag cleared", lo, 16'h0000);
        wreg(`TMR_ADDR_ENABLES, 8'h00);
        endt("clock");

        wreg(`TMR_ADDR_OSC_CTRL, 8'h01);
        cyc(4);
        chk("sec run", srun, 16'h0001);
        chk("status pin", stat, 16'h0001);
        rreg(`TMR_ADDR_CTRL, lo);
        chk("status bit", lo[6], 16'h0001);
        strobe(1'b0);
        chk("sec idle", sidle, 16'h0001);
        strobe(1'b1);
        chk("wake", srun, 16'h0001);
        wreg(`TMR_ADDR_OSC_CTRL, 8'h81);
        strobe(1'b0);
        chk("idle bit set", sidle, 16'h0000);
        wreg(`TMR_ADDR_OSC_CTRL, 8'h00);
        cyc(4);
        chk("status off", stat, 16'h0000);
        wreg(`TMR_ADDR_CTRL, 8'h40);
        rreg(`TMR_ADDR_CTRL, lo);
        chk("status read only", lo, 16'h0000);
        endt("clock mode");
        conclude();
    end
endmodule // test_tmr_top
`default_nettype wire
